//--- sensor_pad_io_control.sv
// Register file and pad control for the auxiliary sensor pads.
// Operation
// - Two-bit field sets drive strength from one to four units.
// - Each pad is input or output; output from data path or register.
// - Vertical sync uses bit 7: direction, select, value.
// - Line-valid pad uses bit 6; select 0 drives internal horizontal sync.
// - Exposure trigger: direction bit 4, select bit 5, value bit 4.
// - Strobe is output only; select bit 4, value bit 2.
// - Frame sync uses bit 3; select 0 drives illumination control.
// - General pad 1 uses bit 1 of the first register set.
// - General pad 2 uses bit 0 of the second register set.
// - General pad 3: direction and select bit 1, value bit 0.
// - General pad 4 uses bit 2 of the second register set.
// - Frame sync is high-impedance in shutdown, input after; test pin is input.
// - Sync, trigger and general pads are high-impedance at and after reset.
`timescale 1ns/1ns
`include "pad_ctrl_consts.svh"
module sensor_pad_io_control (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic shutdown_reset_n_in,
    input wire logic test_mode_pin_in,
    // Register port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire pad_ctrl_pkg::reg_addr_t reg_addr_in,
    input wire pad_ctrl_pkg::reg_byte_t reg_wdata_in,
    output pad_ctrl_pkg::reg_byte_t reg_rdata_out,
    // Internal data path sources
    input wire logic vsync_int_in,
    input wire logic hsync_int_in,
    input wire logic trigger_int_in,
    input wire logic strobe_int_in,
    input wire logic illum_int_in,
    input wire logic [4:0] gp_int_in,
    // Pads: order vsync, line, trigger, strobe, frame sync, gp0..gp4
    input wire pad_ctrl_pkg::pad_vec_t pad_i_in,
    output pad_ctrl_pkg::pad_vec_t pad_o_out,
    output pad_ctrl_pkg::pad_vec_t pad_oe_out,
    output pad_ctrl_pkg::pad_vec_t pad_level_out,
    output pad_ctrl_pkg::drive_units_t drive_units_out
);
    import pad_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    reg_byte_t pad_direction_a;
    reg_byte_t pad_direction_b;
    reg_byte_t pad_out_value_a;
    reg_byte_t pad_out_value_b;
    reg_byte_t pad_out_source_a;
    reg_byte_t pad_out_source_b;
    reg_byte_t pad_drive_strength;
    wire in_reset = rst_in || !shutdown_reset_n_in;
    wire sel_dir_a = reg_addr_in == `ADDR_DIR_A;
    wire sel_dir_b = reg_addr_in == `ADDR_DIR_B;
    wire sel_val_a = reg_addr_in == `ADDR_VAL_A;
    wire sel_val_b = reg_addr_in == `ADDR_VAL_B;
    wire sel_src_a = reg_addr_in == `ADDR_SRC_A;
    wire sel_src_b = reg_addr_in == `ADDR_SRC_B;
    wire sel_drive = reg_addr_in == `ADDR_DRIVE;
    wire wr_dir_a = reg_wr_in && sel_dir_a;
    wire wr_dir_b = reg_wr_in && sel_dir_b;
    wire wr_val_a = reg_wr_in && sel_val_a;
    wire wr_val_b = reg_wr_in && sel_val_b;
    wire wr_src_a = reg_wr_in && sel_src_a;
    wire wr_src_b = reg_wr_in && sel_src_b;
    wire wr_drive = reg_wr_in && sel_drive;

    // Shutdown low clears the registers as well, so all pads but strobe come back high-impedance.
    always_ff @(posedge clock_in) begin
        if (in_reset) pad_direction_a <= `REG_RESET;
        else if (wr_dir_a) pad_direction_a <= reg_wdata_in;
    end

    always_ff @(posedge clock_in) begin
        if (in_reset) pad_direction_b <= `REG_RESET;
        else if (wr_dir_b) pad_direction_b <= reg_wdata_in;
    end

    always_ff @(posedge clock_in) begin
        if (in_reset) pad_out_value_a <= `REG_RESET;
        else if (wr_val_a) pad_out_value_a <= reg_wdata_in;
    end

    always_ff @(posedge clock_in) begin
        if (in_reset) pad_out_value_b <= `REG_RESET;
        else if (wr_val_b) pad_out_value_b <= reg_wdata_in;
    end

    always_ff @(posedge clock_in) begin
        if (in_reset) pad_out_source_a <= `REG_RESET;
        else if (wr_src_a) pad_out_source_a <= reg_wdata_in;
    end

    always_ff @(posedge clock_in) begin
        if (in_reset) pad_out_source_b <= `REG_RESET;
        else if (wr_src_b) pad_out_source_b <= reg_wdata_in;
    end

    always_ff @(posedge clock_in) begin
        if (in_reset) pad_drive_strength <= `REG_RESET;
        else if (wr_drive) pad_drive_strength <= reg_wdata_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    reg_byte_t next_rdata;
    always_comb begin
        if (sel_dir_a) next_rdata = pad_direction_a;
        else if (sel_dir_b) next_rdata = pad_direction_b;
        else if (sel_val_a) next_rdata = pad_out_value_a;
        else if (sel_val_b) next_rdata = pad_out_value_b;
        else if (sel_src_a) next_rdata = pad_out_source_a;
        else if (sel_src_b) next_rdata = pad_out_source_b;
        else if (sel_drive) next_rdata = pad_drive_strength;
        else next_rdata = 8'h00;
    end
    always_ff @(posedge clock_in) begin
        if (in_reset) reg_rdata_out <= `REG_RESET;
        else if (reg_rd_in) reg_rdata_out <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////////
    pad_cfg_if cfg ();
    // Strobe has no direction bit, so it is an output from the first clock edge after reset clears.
    wire vsync_dir = pad_direction_a[`BIT_VSYNC];
    wire line_dir = pad_direction_a[`BIT_LINE];
    wire trig_dir = pad_direction_a[`BIT_TRIG_DIR];
    wire strobe_dir = 1'b1;
    wire fsync_dir = pad_direction_a[`BIT_FSYNC];
    wire gp0_dir = pad_direction_a[`BIT_GP0];
    wire gp1_dir = pad_direction_a[`BIT_GP1];
    wire gp2_dir = pad_direction_b[`BIT_GP2];
    wire gp3_dir = pad_direction_b[`BIT_GP3];
    wire gp4_dir = pad_direction_b[`BIT_GP4];
    // Software must also clear the analog enable for gp0; that bit lives elsewhere.
    wire vsync_src = pad_out_source_a[`BIT_VSYNC];
    wire line_src = pad_out_source_a[`BIT_LINE];
    wire trig_src = pad_out_source_a[`BIT_TRIG_SRC];
    wire strobe_src = pad_out_source_a[`BIT_STROBE_SRC];
    wire fsync_src = pad_out_source_a[`BIT_FSYNC];
    wire gp0_src = pad_out_source_a[`BIT_GP0];
    wire gp1_src = pad_out_source_a[`BIT_GP1];
    wire gp2_src = pad_out_source_b[`BIT_GP2];
    wire gp3_src = pad_out_source_b[`BIT_GP3];
    wire gp4_src = pad_out_source_b[`BIT_GP4];
    // Gp3 shares gp2's value bit, so both follow one bit until a separate one is confirmed.
    wire vsync_val = pad_out_value_a[`BIT_VSYNC];
    wire line_val = pad_out_value_a[`BIT_LINE];
    wire trig_val = pad_out_value_a[`BIT_TRIG_VAL];
    wire strobe_val = pad_out_value_a[`BIT_STROBE_VAL];
    wire fsync_val = pad_out_value_a[`BIT_FSYNC];
    wire gp0_val = pad_out_value_a[`BIT_GP0];
    wire gp1_val = pad_out_value_a[`BIT_GP1];
    wire gp2_val = pad_out_value_b[`BIT_GP2];
    wire gp3_val = pad_out_value_b[`BIT_GP3_VAL];
    wire gp4_val = pad_out_value_b[`BIT_GP4];
    assign cfg.dir = {gp4_dir,
                      gp3_dir,
                      gp2_dir,
                      gp1_dir,
                      gp0_dir,
                      fsync_dir,
                      strobe_dir,
                      trig_dir,
                      line_dir,
                      vsync_dir};
    assign cfg.src = {gp4_src,
                      gp3_src,
                      gp2_src,
                      gp1_src,
                      gp0_src,
                      fsync_src,
                      strobe_src,
                      trig_src,
                      line_src,
                      vsync_src};
    assign cfg.val = {gp4_val,
                      gp3_val,
                      gp2_val,
                      gp1_val,
                      gp0_val,
                      fsync_val,
                      strobe_val,
                      trig_val,
                      line_val,
                      vsync_val};
    wire pad_vec_t internal_src = {gp_int_in, illum_int_in, strobe_int_in,
                                   trigger_int_in, hsync_int_in, vsync_int_in};
    pad_vec_t mux_oe;
    pad_mux u_mux (
        .clock_in(clock_in),
        .rst_in(in_reset),
        .cfg(cfg.mux),
        .internal_in(internal_src),
        .pad_o_out(pad_o_out),
        .pad_oe_out(mux_oe)
    );
    // The strobe enable drops in reset with the rest, as every enable is one flip-flop.
    assign pad_oe_out = mux_oe;

    ////////////////////////////////////////////////////////////////////////////////
    wire [1:0] drive_code = pad_drive_strength[`DRIVE_MSB:`DRIVE_LSB];
    wire drive_units_t next_drive_units = 4'({2'b00, drive_code} + 4'h1);
    wire pad_vec_t next_level = pad_i_in & ~mux_oe;
    always_ff @(posedge clock_in) begin
        if (in_reset) drive_units_out <= `DRIVE_UNITS_RESET;
        else drive_units_out <= next_drive_units;
    end

    always_ff @(posedge clock_in) begin
        if (in_reset) pad_level_out <= '0;
        else pad_level_out <= next_level;
    end
    // The test pin is input only and has no control here.
    wire unused_tm = test_mode_pin_in;
endmodule // sensor_pad_io_control

//--- pad_ctrl_consts.svh
// Register offsets, field positions and reset values for the pad control block.
`ifndef PAD_CTRL_CONSTS_SVH
`define PAD_CTRL_CONSTS_SVH
`define ADDR_DIR_B 16'h3001
`define ADDR_DIR_A 16'h3002
`define ADDR_VAL_B 16'h3004
`define ADDR_VAL_A 16'h3005
`define ADDR_SRC_B 16'h3007
`define ADDR_SRC_A 16'h3008
`define ADDR_DRIVE 16'h3009
`define REG_RESET 8'h00
`define DRIVE_UNITS_RESET 4'h1
`define DRIVE_LSB 5
`define DRIVE_MSB 6
`define BIT_VSYNC 7
`define BIT_LINE 6
`define BIT_TRIG_DIR 4
`define BIT_TRIG_SRC 5
`define BIT_TRIG_VAL 4
`define BIT_STROBE_SRC 4
`define BIT_STROBE_VAL 2
`define BIT_FSYNC 3
`define BIT_GP0 0
`define BIT_GP1 1
`define BIT_GP2 0
`define BIT_GP3 1
`define BIT_GP3_VAL 0
`define BIT_GP4 2
`define NUM_PADS 10
`endif

//--- pad_ctrl_pkg.sv
// Types shared by the pad control modules.
package pad_ctrl_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [15:0] reg_addr_t;
    typedef logic [9:0] pad_vec_t;
    typedef logic [3:0] drive_units_t;
endpackage

//--- pad_cfg_if.sv
// Per-pad configuration carried from the register file to the pad mux.
`timescale 1ns/1ns
interface pad_cfg_if;
    import pad_ctrl_pkg::*;
    pad_vec_t dir;
    pad_vec_t src;
    pad_vec_t val;
    modport regs (output dir, output src, output val);
    modport mux (input dir, input src, input val);
endinterface

//--- pad_mux.sv
// Output mux and enable generation for every configurable pad.
`timescale 1ns/1ns
module pad_mux (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Configuration
    pad_cfg_if.mux cfg,
    input wire pad_ctrl_pkg::pad_vec_t internal_in,
    // Pad drive
    output pad_ctrl_pkg::pad_vec_t pad_o_out,
    output pad_ctrl_pkg::pad_vec_t pad_oe_out
);
    import pad_ctrl_pkg::*;
    pad_vec_t next_o;
    pad_vec_t next_oe;
    genvar i;
    generate
        for (i = 0; i < 10; i = i + 1) begin : g_pad
            // Select picks register value or internal path.
            assign next_o[i] = cfg.src[i] ? cfg.val[i] : internal_in[i];
            // An input never drives, but select and value still sit ready for output.
            assign next_oe[i] = cfg.dir[i];
        end
    endgenerate
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pad_o_out <= '0;
            pad_oe_out <= '0;
        end else begin
            pad_o_out <= next_o;
            pad_oe_out <= next_oe;
        end
    end
endmodule // pad_mux

//--- sensor_pad_io_control_assertions.sv
// Checker for pad enables, pad levels and drive units.
`timescale 1ns/1ns
module sensor_pad_io_control_assertions (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic shutdown_reset_n_in,
    // Register writes
    input wire logic reg_wr_in,
    input wire pad_ctrl_pkg::reg_addr_t reg_addr_in,
    input wire pad_ctrl_pkg::reg_byte_t reg_wdata_in,
    // Internal sources
    input wire logic vsync_int_in,
    input wire logic hsync_int_in,
    input wire logic trigger_int_in,
    input wire logic strobe_int_in,
    input wire logic illum_int_in,
    input wire logic [4:0] gp_int_in,
    // Pads
    input wire pad_ctrl_pkg::pad_vec_t pad_o_out,
    input wire pad_ctrl_pkg::pad_vec_t pad_oe_out,
    input wire pad_ctrl_pkg::drive_units_t drive_units_out
);
    import pad_ctrl_pkg::*;
    reg_byte_t da, db, sa, sb, va, vb, dr;
    pad_vec_t oe_q, o_q;
    wire rs = rst_in || !shutdown_reset_n_in;
    // Gp3 shares value bit 0 with gp2, so both follow vb[0].
    wire pad_vec_t s = {sb[2:0], sa[1:0], sa[3], sa[4], sa[5], sa[6], sa[7]};
    wire pad_vec_t v = {vb[2], vb[0], vb[0], va[1:0], va[3], va[2], va[4], va[6], va[7]};
    wire pad_vec_t n = {gp_int_in, illum_int_in, strobe_int_in, trigger_int_in, hsync_int_in,
        vsync_int_in};
    wire pad_vec_t e_oe = {db[2:0], da[1:0], da[3], 1'b1, da[4], da[6], da[7]};
    wire pad_vec_t good = ~(pad_oe_out ^ oe_q) & ~(pad_oe_out & (pad_o_out ^ o_q));
    always_ff @(posedge clock_in) begin
        if (rs) begin
            {da, db, sa, sb, va, vb, dr} <= '0;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                16'h3001: db <= reg_wdata_in;
                16'h3002: da <= reg_wdata_in;
                16'h3004: vb <= reg_wdata_in;
                16'h3005: va <= reg_wdata_in;
                16'h3007: sb <= reg_wdata_in;
                16'h3008: sa <= reg_wdata_in;
                16'h3009: dr <= reg_wdata_in;
                default: ;
            endcase
        end
    end
    // The expected pads leave reset quiet, like the design's own flip-flops.
    always_ff @(posedge clock_in) begin
        if (rs) begin
            oe_q <= '0;
            o_q <= '0;
        end else begin
            oe_q <= e_oe;
            o_q <= (s & v) | (~s & n);
        end
    end
    AST_DRIVE: assert property (@(posedge clock_in) disable iff (rs)
        drive_units_out == {2'b00, $past(dr[6:5])} + 4'h1) else $error("drive units wrong");
    AST_VSYNC: assert property (@(posedge clock_in) disable iff (rs) good[0])
        else $error("vsync pad wrong");
    AST_LINE: assert property (@(posedge clock_in) disable iff (rs) good[1])
        else $error("line pad wrong");
    AST_TRIG: assert property (@(posedge clock_in) disable iff (rs) good[2])
        else $error("trigger pad wrong");
    AST_STROBE: assert property (@(posedge clock_in) disable iff (rs)
        $past(rs) || (pad_oe_out[3] && good[3])) else $error("strobe pad wrong");
    AST_FSYNC: assert property (@(posedge clock_in) disable iff (rs) good[4])
        else $error("frame sync pad wrong");
    AST_GP_LOW: assert property (@(posedge clock_in) disable iff (rs)
        good[6:5] == 2'b11) else $error("gp pad 0 or 1 wrong");
    AST_GP_HIGH: assert property (@(posedge clock_in) disable iff (rs)
        good[9:7] == 3'b111) else $error("gp pad 2 to 4 wrong");
    AST_RESET_HIZ: assert property (@(posedge clock_in)
        rs [*2] |-> pad_oe_out == 10'h000) else $error("pad driven in reset");
endmodule // sensor_pad_io_control_assertions

//--- pad_board_model.sv
// Board circuitry on the auxiliary pads.
`timescale 1ns/1ns
module pad_board_model (
    // Sensor side
    input wire pad_ctrl_pkg::pad_vec_t pad_o_in,
    input wire pad_ctrl_pkg::pad_vec_t pad_oe_in,
    // Board side
    input wire pad_ctrl_pkg::pad_vec_t board_in,
    output pad_ctrl_pkg::pad_vec_t wire_out
);
    // The board yields any pad the sensor drives, so a clash never hides a bad enable.
    assign wire_out = (pad_oe_in & pad_o_in) | (~pad_oe_in & board_in);
endmodule // pad_board_model

//--- sensor_pad_io_control_test.sv
// Table-driven bench for the auxiliary pad control block.
`timescale 1ns/1ns
module sensor_pad_io_control_test;
    import pad_ctrl_pkg::*;
    typedef struct packed {
        reg_byte_t da, db, sa, sb, va, vb, dr;
        pad_vec_t nv, oe, o;
        drive_units_t du;
    } row_t;
    logic clock_in = 1'b0, rst_in = 1'b1, shutdown_n = 1'b1, wr = 1'b0, rd = 1'b0;
    reg_addr_t addr = 16'h0000;
    reg_byte_t wdata = 8'h00, rdata;
    reg_byte_t rv [7];
    pad_vec_t nv = 10'h000, board = 10'h2A5, pin, po, poe, plev;
    drive_units_t du;
    int num_errors = 0, num_checks = 0;
    reg_addr_t amap [7] = '{16'h3002, 16'h3001, 16'h3008, 16'h3007, 16'h3005, 16'h3004, 16'h3009};
    row_t rows [6] = '{
        '{8'hFF, 8'h07, 8'hFF, 8'h07, 8'hAA, 8'h01, 8'h00, 10'h000, 10'h3FF, 10'h1D1, 4'h1},
        '{8'hFF, 8'h07, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h20, 10'h2B5, 10'h3FF, 10'h2B5, 4'h2},
        '{8'h00, 8'h00, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'h40, 10'h3FF, 10'h008, 10'h008, 4'h3},
        '{8'h50, 8'h02, 8'h40, 8'h00, 8'h40, 8'h04, 8'h60, 10'h0FF, 10'h10E, 10'h00E, 4'h4},
        '{8'h00, 8'h07, 8'h00, 8'h07, 8'h00, 8'h01, 8'h9F, 10'h000, 10'h388, 10'h180, 4'h1},
        '{8'h00, 8'h07, 8'h00, 8'h07, 8'h00, 8'h06, 8'hFF, 10'h000, 10'h388, 10'h200, 4'h4}};
    sensor_pad_io_control DUT (.clock_in, .rst_in, .shutdown_reset_n_in(shutdown_n),
        .test_mode_pin_in(1'b0), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .vsync_int_in(nv[0]), .hsync_int_in(nv[1]),
        .trigger_int_in(nv[2]), .strobe_int_in(nv[3]), .illum_int_in(nv[4]), .gp_int_in(nv[9:5]),
        .pad_i_in(pin), .pad_o_out(po), .pad_oe_out(poe), .pad_level_out(plev),
        .drive_units_out(du));
    pad_board_model board_model (.pad_o_in(po), .pad_oe_in(poe), .board_in(board), .wire_out(pin));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(int n = 1);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic chk(string what, pad_vec_t exp, pad_vec_t seen);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_write(reg_addr_t a, reg_byte_t d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick();
        wr = 1'b0;
        tick();
    endtask
    task automatic reg_check(reg_addr_t a, reg_byte_t e);
        addr = a;
        rd = 1'b1;
        tick();
        rd = 1'b0;
        chk("read data", {2'b00, e}, {2'b00, rdata});
        tick();
    endtask
    task automatic end_sim();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #50 clock_in = ~clock_in;
    end
    initial begin
        repeat (3000) @(posedge clock_in);
        num_errors++;
        end_sim();
    end
    initial begin
        tick(10);
        rst_in = 1'b0;
        foreach (amap[k]) reg_check(amap[k], 8'h00);
        chk("pad enable", 10'h008, poe);
        chk("drive units", 10'h001, {6'h00, du});
        foreach (rows[i]) begin
            nv = rows[i].nv;
            rv = '{rows[i].da, rows[i].db, rows[i].sa, rows[i].sb, rows[i].va, rows[i].vb, rows[i].dr};
            foreach (amap[k]) reg_write(amap[k], rv[k]);
            tick(2);
            chk("pad enable", rows[i].oe, poe);
            chk("pad level", rows[i].o, po & poe);
            chk("input level", board & ~rows[i].oe, plev);
            chk("drive units", {6'h00, rows[i].du}, {6'h00, du});
            foreach (amap[k]) reg_check(amap[k], rv[k]);
        end
        reg_write(16'h3003, 8'hFF);
        reg_check(16'h3003, 8'h00);
        shutdown_n = 1'b0;
        tick(2);
        chk("pad enable", 10'h000, poe);
        chk("input level", 10'h000, plev);
        shutdown_n = 1'b1;
        tick();
        chk("pad enable", 10'h008, poe);
        chk("input level", board & ~10'h008, plev);
        reg_check(16'h3001, 8'h00);
        end_sim();
    end
endmodule // sensor_pad_io_control_test
bind sensor_pad_io_control sensor_pad_io_control_assertions checks (.clock_in, .rst_in,
    .shutdown_reset_n_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .vsync_int_in, .hsync_int_in,
    .trigger_int_in, .strobe_int_in, .illum_int_in, .gp_int_in, .pad_o_out, .pad_oe_out,
    .drive_units_out);
